// [iecm_pkg.sv]
// Package of opcodes, cost constants and enumerations for the interrupt entry cycle model
package iecm_pkg;

  // ----------------------------------------------------------------
  // Opcodes and vector numbers
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_TRAP_IMM = 8'h00CD;
  localparam logic [7:0] OPC_BREAKPOINT = 8'h00CC;
  localparam logic [7:0] OPC_OVERFLOW_TRAP = 8'h00CE;
  localparam logic [7:0] OPC_RANGE_CHECK = 8'h0062;
  localparam logic [7:0] OPC_HANDLER_RETURN = 8'h00CF;
  localparam logic [7:0] VEC_BREAKPOINT = 8'h0003;
  localparam logic [7:0] VEC_OVERFLOW = 8'h0004;
  localparam logic [7:0] VEC_RANGE = 8'h0005;
  localparam logic [7:0] VEC_PROTECTION = 8'h000D;
  localparam logic [7:0] VEC_PAGE_FAULT = 8'h000E;
  localparam logic [7:0] VEC_NMI = 8'h0002;

  // ----------------------------------------------------------------
  // Cycle costs (width of the cost arithmetic)
  // ----------------------------------------------------------------
  localparam int CW = 12;
  localparam logic [11:0] C_IMM_RV = 12'h0004;
  localparam logic [11:0] C_IMM_P = 12'h0000;
  localparam logic [11:0] C_BRK = 12'h0000;
  localparam logic [11:0] C_OVF_TAKEN = 12'h0002;
  localparam logic [11:0] C_OVF_NOT = 12'h0003;
  localparam logic [11:0] C_RNG_IN = 12'h0007;
  localparam logic [11:0] C_RNG_OUT = 12'h0018;
  localparam logic [11:0] P_RNG = 12'h0007;
  localparam logic [11:0] C_RET_RV = 12'h000F;
  localparam logic [11:0] P_RET_RV = 12'h0008;
  localparam logic [11:0] C_RET_SAME = 12'h0014;
  localparam logic [11:0] P_RET_SAME = 12'h000B;
  localparam logic [11:0] C_RET_OUTER = 12'h0024;
  localparam logic [11:0] P_RET_OUTER = 12'h0013;
  localparam logic [11:0] C_RET_NEST = 12'h0020;
  localparam logic [11:0] P_RET_NEST = 12'h0004;
  localparam logic [11:0] C_NMI = 12'h0003;
  localparam logic [11:0] C_EXT = 12'h000B;
  localparam logic [11:0] C_PF = 12'h0018;
  localparam logic [11:0] V_REAL = 12'h001A;
  localparam logic [11:0] VP_REAL = 12'h0002;
  localparam logic [11:0] V_SAME = 12'h002C;
  localparam logic [11:0] VP_SAME = 12'h0006;
  localparam logic [11:0] V_DIFF_P = 12'h0047;
  localparam logic [11:0] V_DIFF_V = 12'h0052;
  localparam logic [11:0] VP_DIFF = 12'h0011;
  localparam logic [11:0] V_TASK = 12'h0025;
  localparam logic [11:0] VP_TASK = 12'h0003;
  localparam logic [11:0] TS_32 = 12'h00A2;
  localparam logic [11:0] TSP_32 = 12'h0037;
  localparam logic [11:0] TS_16 = 12'h008F;
  localparam logic [11:0] TSP_16 = 12'h001F;
  localparam logic [11:0] TS_VM = 12'h008C;
  localparam logic [11:0] TSP_VM = 12'h0025;
  localparam logic [11:0] C_DESC = 12'h000B;
  localparam logic [11:0] C_COPY16 = 12'h0006;
  localparam logic [11:0] C_VM_FLAG = 12'h0008;
  localparam logic [11:0] C_VM_TRAP = 12'h0009;
  localparam logic [11:0] C_VM_IO = 12'h0032;
  localparam logic [11:0] C_VM_IO_ALT = 12'h0033;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_REAL = 2'b00,
    MODE_PROT = 2'b01,
    MODE_VIRT = 2'b10
  } iecm_mode_t;

  typedef enum logic [1:0] {
    GATE_SAME = 2'b00,
    GATE_DIFF = 2'b01,
    GATE_TASK = 2'b10
  } iecm_gate_t;

  typedef enum logic [1:0] {
    TSS_32 = 2'b00,
    TSS_16 = 2'b01,
    TSS_VM = 2'b10
  } iecm_tss_t;

  typedef enum logic [3:0] {
    EV_NONE = 4'b0000,
    EV_NMI = 4'b0001,
    EV_EXT = 4'b0010,
    EV_PAGE_FAULT = 4'b0011,
    EV_VM_FLAG = 4'b0100,
    EV_VM_TRAP = 4'b0101,
    EV_VM_IO = 4'b0110,
    EV_VM_IO_ALT = 4'b0111
  } iecm_event_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_COUNT = 1'b1
  } iecm_state_t;

endpackage : iecm_pkg

// [iecm_core.sv]
// Cycle model of trap, interrupt entry, handler return and task switch timing
`timescale 1ns/1ps
`default_nettype none
module iecm_core
  import iecm_pkg::*;
#(
  parameter int CNT_W = 12
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [7:0] vector_in,
  input wire logic [3:0] event_kind,
  input wire logic [1:0] mode,
  input wire logic [1:0] gate_kind,
  input wire logic [1:0] tss_kind,
  input wire logic overflow_flag,
  input wire logic out_of_range,
  input wire logic return_outer,
  input wire logic nested_task_flag,
  input wire logic cache_miss,
  input wire logic [2:0] unaccessed_desc,
  input wire logic [7:0] copy_blocks,
  output logic busy,
  output logic done,
  output logic vector_taken,
  output logic [7:0] vector_out,
  output logic [CNT_W-1:0] cost,
  output logic illegal_op
);

  // ----------------------------------------------------------------
  // Cost evaluation
  // ----------------------------------------------------------------
  iecm_state_t state;
  logic [CNT_W-1:0] remain;
  logic [CNT_W-1:0] next_cost;
  logic [7:0] next_vector;
  logic next_taken;
  logic next_illegal;
  logic [CW-1:0] ts_val;
  logic [CW-1:0] vec_val;
  logic [CW-1:0] extra;
  logic [CW-1:0] miss;
  logic [CW-1:0] desc_add;
  logic [CW-1:0] copy_add;
  logic [CW-1:0] raw;
  iecm_event_t ev;

  assign ev = iecm_event_t'(event_kind);

  always_comb begin
    unique case (tss_kind)
      TSS_16: ts_val = TS_16 + (cache_miss ? TSP_16 : '0);
      TSS_VM: ts_val = TS_VM + (cache_miss ? TSP_VM : '0);
      default: ts_val = TS_32 + (cache_miss ? TSP_32 : '0);
    endcase
  end

  assign desc_add = CW'(unaccessed_desc) * C_DESC;
  assign copy_add = cache_miss ? CW'(copy_blocks) * C_COPY16 : '0;

  // vectoring cost by mode and gate
  always_comb begin
    vec_val = V_REAL + (cache_miss ? VP_REAL : '0);
    if (mode != MODE_REAL) begin
      if (gate_kind == GATE_TASK) begin
        vec_val = V_TASK + ts_val + (cache_miss ? VP_TASK : '0);
      end else if (gate_kind == GATE_DIFF) begin
        vec_val = ((mode == MODE_VIRT) ? V_DIFF_V : V_DIFF_P) + (cache_miss ? VP_DIFF : '0) + copy_add;
      end else begin
        vec_val = V_SAME + (cache_miss ? VP_SAME : '0);
      end
      vec_val = vec_val + desc_add;
    end
  end

  // issue-to-handler total, penalties on miss only
  always_comb begin
    next_taken = 1'b1;
    next_illegal = 1'b0;
    next_vector = vector_in;
    extra = '0;
    miss = '0;
    raw = '0;
    if (ev != EV_NONE) begin
      unique case (ev)
        EV_NMI: begin
          extra = C_NMI;
          next_vector = VEC_NMI;
        end
        EV_EXT: extra = C_EXT;
        EV_PAGE_FAULT: begin
          extra = C_PF;
          next_vector = VEC_PAGE_FAULT;
        end
        EV_VM_FLAG: begin
          extra = C_VM_FLAG;
          next_vector = VEC_PROTECTION;
        end
        EV_VM_TRAP: begin
          extra = C_VM_TRAP;
          next_vector = VEC_PROTECTION;
        end
        EV_VM_IO: begin
          extra = C_VM_IO;
          next_vector = VEC_PROTECTION;
        end
        EV_VM_IO_ALT: begin
          extra = C_VM_IO_ALT;
          next_vector = VEC_PROTECTION;
        end
        default: next_illegal = 1'b1;
      endcase
      raw = vec_val + extra;
    end else begin
      unique case (opcode)
        OPC_TRAP_IMM: raw = vec_val + ((mode == MODE_PROT) ? C_IMM_P : C_IMM_RV);
        OPC_BREAKPOINT: begin
          raw = vec_val + C_BRK;
          next_vector = VEC_BREAKPOINT;
        end
        OPC_OVERFLOW_TRAP: begin
          next_vector = VEC_OVERFLOW;
          next_taken = overflow_flag;
          raw = overflow_flag ? vec_val + C_OVF_TAKEN : C_OVF_NOT;
        end
        OPC_RANGE_CHECK: begin
          next_vector = VEC_RANGE;
          next_taken = out_of_range;
          miss = cache_miss ? P_RNG : '0;
          raw = (out_of_range ? vec_val + C_RNG_OUT : C_RNG_IN) + miss;
        end
        OPC_HANDLER_RETURN: begin
          next_taken = 1'b0;
          next_vector = 8'h0000;
          if (nested_task_flag && mode != MODE_REAL) begin
            raw = ts_val + C_RET_NEST + (cache_miss ? P_RET_NEST : '0) + desc_add;
          end else if (mode != MODE_PROT) begin
            raw = C_RET_RV + (cache_miss ? P_RET_RV : '0);
          end else if (return_outer) begin
            raw = C_RET_OUTER + (cache_miss ? P_RET_OUTER : '0) + desc_add;
          end else begin
            raw = C_RET_SAME + (cache_miss ? P_RET_SAME : '0) + desc_add;
          end
        end
        default: begin
          next_taken = 1'b0;
          next_illegal = 1'b1;
        end
      endcase
    end
    next_cost = CNT_W'(raw);
  end

  // ----------------------------------------------------------------
  // Sequencer: busy for the whole count, done pulse at its end
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      remain <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (start && !next_illegal && next_cost != '0) begin
            state <= ST_COUNT;
            remain <= next_cost;
            busy <= 1'b1;
          end else if (start) begin
            done <= 1'b1;
          end
        end
        ST_COUNT: begin
          if (remain == CNT_W'(1)) begin
            state <= ST_IDLE;
            busy <= 1'b0;
            done <= 1'b1;
          end
          remain <= remain - CNT_W'(1);
        end
      endcase
    end
  end

  // Results are latched at issue so the inputs may change while counting
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cost <= '0;
      vector_out <= 8'h0000;
      vector_taken <= 1'b0;
      illegal_op <= 1'b0;
    end else if (start && state == ST_IDLE) begin
      cost <= next_illegal ? '0 : next_cost;
      vector_out <= next_vector;
      vector_taken <= next_taken && !next_illegal;
      illegal_op <= next_illegal;
    end
  end

endmodule : iecm_core
`default_nettype wire

// [iecm_monitor.sv]
// Checker of handshake timing and decoded vectors of the interrupt entry cycle model
`timescale 1ns/1ps
`default_nettype none
module iecm_monitor
  import iecm_pkg::*;
#(
  parameter int CNT_W = 12
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [3:0] event_kind,
  input wire logic overflow_flag,
  input wire logic busy,
  input wire logic done,
  input wire logic vector_taken,
  input wire logic [7:0] vector_out,
  input wire logic [CNT_W-1:0] cost
);
  // ----------------------------------------
  // Busy length, compared with cost at done
  // ----------------------------------------
  logic [15:0] run_len;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      run_len <= 16'h0000;
    end else if (start && !busy) begin
      run_len <= 16'h0000;
    end else if (busy) begin
      run_len <= run_len + 16'h0001;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_take;
    start && !busy;
  endsequence
  sequence s_opc(logic [7:0] op);
    s_take ##0 (event_kind == 4'h0 && opcode == op);
  endsequence
  take_answer_a: assert property (s_take |=> busy != done) else $error("no answer");
  done_once_a: assert property (done && !start |=> !done) else $error("done held");
  busy_len_a: assert property (done && $past(busy) |-> run_len[CNT_W-1:0] == cost) else $error("busy length");
  refuse_hold_a: assert property (busy && start |=> $stable(cost) && $stable(vector_out)) else $error("refused");
  brk_vector_a: assert property (s_opc(OPC_BREAKPOINT) |=> vector_taken && vector_out == 8'h03) else $error("brk");
  ovf_skip_a: assert property (s_opc(OPC_OVERFLOW_TRAP) ##0 !overflow_flag |=> !vector_taken && cost == 3) else $error("ovf");
  ovf_take_a: assert property (s_opc(OPC_OVERFLOW_TRAP) ##0 overflow_flag |=> vector_out == 8'h04) else $error("ovf");
  nmi_vector_a: assert property (s_take ##0 event_kind == 4'h1 |=> vector_taken && vector_out == 8'h02) else $error("nmi");
endmodule : iecm_monitor
bind iecm_core iecm_monitor #(.CNT_W(CNT_W)) u_mon (.mclk, .nrst, .start, .opcode, .event_kind, .overflow_flag,
  .busy, .done, .vector_taken, .vector_out, .cost);
`default_nettype wire

// [tb_interrupt_entry_cycle_model.sv]
// Self-checking bench of the interrupt entry cycle model
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_entry_cycle_model;
  import iecm_pkg::*;
  logic mclk = 1'b0, nrst = 1'b0, start = 1'b0, overflow_flag = 1'b0, out_of_range = 1'b0;
  logic return_outer = 1'b0, nested_task_flag = 1'b0, cache_miss = 1'b0;
  logic [7:0] opcode = 8'h00, vector_in = 8'h00, copy_blocks = 8'h00;
  logic [3:0] event_kind = 4'h0;
  logic [1:0] mode = 2'b00, gate_kind = 2'b00, tss_kind = 2'b00;
  logic [2:0] unaccessed_desc = 3'h0;
  logic busy, done, vector_taken, illegal_op;
  logic [7:0] vector_out;
  logic [11:0] cost;
  int n_fail = 0;
  int num_checks = 0;
  iecm_core #(.CNT_W(12)) DUT (.mclk, .nrst, .start, .opcode, .vector_in, .event_kind, .mode, .gate_kind,
    .tss_kind, .overflow_flag, .out_of_range, .return_outer, .nested_task_flag, .cache_miss, .unaccessed_desc,
    .copy_blocks, .busy, .done, .vector_taken, .vector_out, .cost, .illegal_op);
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  // Start may be held while busy to show it is refused; config is cleared once taken
  task automatic go(input logic [11:0] ec, input logic [7:0] ev, input logic et, input logic il = 1'b0,
                    input int hold = 0);
    int n;
    n = hold + 1;
    start <= 1'b1;
    repeat (hold + 1) @(posedge mclk);
    start <= 1'b0;
    {overflow_flag, out_of_range, return_outer, nested_task_flag, cache_miss} <= 5'b00000;
    {event_kind, mode, gate_kind, tss_kind, unaccessed_desc, copy_blocks} <= 21'h00_0000;
    // Look before waiting: a zero-cost or illegal request raises done in the cycle just after the take
    #1;
    while (done !== 1'b1 && n < 400) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check("cycles", 12'(n), ec + 12'h0001);
    check("illegal", 12'(illegal_op), 12'(il));
    if (!il) check("cost", cost, ec);
    if (!il) check("taken", 12'(vector_taken), 12'(et));
    if (et) check("vector", 12'(vector_out), 12'(ev));
  endtask : go
  task automatic t_brk();
    @(posedge mclk) opcode <= OPC_BREAKPOINT;
    go(12'h001A, 8'h03, 1'b1, 1'b0, 2);
  endtask : t_brk
  task automatic t_imm();
    @(posedge mclk) {opcode, vector_in} <= {OPC_TRAP_IMM, 8'h21};
    go(12'h001E, 8'h21, 1'b1);
    @(posedge mclk) {vector_in, mode} <= {8'h22, MODE_PROT};
    go(12'h002C, 8'h22, 1'b1);
  endtask : t_imm
  task automatic t_ovf();
    @(posedge mclk) opcode <= OPC_OVERFLOW_TRAP;
    go(12'h0003, 8'h00, 1'b0);
    @(posedge mclk) overflow_flag <= 1'b1;
    go(12'h001C, 8'h04, 1'b1);
  endtask : t_ovf
  task automatic t_rng();
    @(posedge mclk) {opcode, cache_miss} <= {OPC_RANGE_CHECK, 1'b1};
    go(12'h000E, 8'h00, 1'b0);
    @(posedge mclk) {out_of_range, mode} <= {1'b1, MODE_PROT};
    go(12'h0044, 8'h05, 1'b1);
  endtask : t_rng
  task automatic t_ret();
    @(posedge mclk) opcode <= OPC_HANDLER_RETURN;
    go(12'h000F, 8'h00, 1'b0);
    @(posedge mclk) {mode, return_outer} <= {MODE_PROT, 1'b1};
    go(12'h0024, 8'h00, 1'b0);
    @(posedge mclk) {mode, cache_miss} <= {MODE_PROT, 1'b1};
    go(12'h001F, 8'h00, 1'b0);
    @(posedge mclk) {mode, unaccessed_desc} <= {MODE_PROT, 3'h2};
    go(12'h002A, 8'h00, 1'b0);
    @(posedge mclk) {mode, nested_task_flag} <= {MODE_PROT, 1'b1};
    go(12'h00C2, 8'h00, 1'b0);
    @(posedge mclk) {mode, nested_task_flag, tss_kind} <= {MODE_PROT, 1'b1, TSS_VM};
    go(12'h00AC, 8'h00, 1'b0);
  endtask : t_ret
  task automatic t_ent();
    @(posedge mclk) event_kind <= EV_NMI;
    go(12'h001D, 8'h02, 1'b1);
    @(posedge mclk) {event_kind, vector_in, cache_miss} <= {EV_EXT, 8'h40, 1'b1};
    go(12'h0027, 8'h40, 1'b1);
    @(posedge mclk) {event_kind, mode, gate_kind, unaccessed_desc} <= {EV_PAGE_FAULT, MODE_PROT, GATE_DIFF, 3'h2};
    go(12'h0075, 8'h0E, 1'b1);
    @(posedge mclk) {event_kind, mode, gate_kind, tss_kind} <= {EV_NMI, MODE_PROT, GATE_TASK, TSS_16};
    go(12'h00B7, 8'h02, 1'b1);
    @(posedge mclk) {event_kind, mode, gate_kind, cache_miss, copy_blocks} <= {EV_EXT, MODE_PROT, GATE_DIFF, 9'h103};
    go(12'h0075, 8'h40, 1'b1);
  endtask : t_ent
  task automatic t_vm();
    logic [11:0] extra [4] = '{12'h0008, 12'h0009, 12'h0032, 12'h0033};
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk) {event_kind, mode, gate_kind} <= {4'(4 + k), MODE_VIRT, GATE_DIFF};
      go(12'h0052 + extra[k], 8'h0D, 1'b1);
    end
    @(posedge mclk) {event_kind, mode, gate_kind, cache_miss} <= {EV_VM_TRAP, MODE_VIRT, GATE_TASK, 1'b1};
    go(12'h010A, 8'h0D, 1'b1);
    @(posedge mclk) event_kind <= 4'h8;
    go(12'h0000, 8'h00, 1'b0, 1'b1);
    @(posedge mclk) opcode <= 8'h90;
    go(12'h0000, 8'h00, 1'b0, 1'b1);
  endtask : t_vm
  initial begin
    forever #5 mclk = ~mclk;
  end
  initial begin
    #100000;
    n_fail++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    t_brk();
    t_imm();
    t_ovf();
    t_rng();
    t_ret();
    t_ent();
    t_vm();
    finish_test();
  end
endmodule : tb_interrupt_entry_cycle_model
`default_nettype wire
